// >>> shared/gib_defs.vh
// register offsets, field positions and widths for the global irq and boot status block
`ifndef GIB_DEFS_VH
`define GIB_DEFS_VH
`define GIB_ADDR_W          16
`define GIB_DATA_W          8
`define GIB_NUM_REF         2
`define GIB_ADDR_INT_STAT   16'h0200
`define GIB_ADDR_INT_EN     16'h0208
`define GIB_ADDR_SUMMARY    16'h020d
`define GIB_ADDR_RSVD_A     16'h020e
`define GIB_ADDR_RSVD_B     16'h020f
`define GIB_ADDR_BOOT_ERR   16'h0210
`define GIB_ADDR_BOOT_DONE  16'h0211
`define GIB_ADDR_RSVD_C     16'h0212
`define GIB_BIT_LOS0        0
`define GIB_BIT_LOS1        1
`define GIB_BIT_HOLD        4
`define GIB_BIT_LOL         6
`define GIB_BIT_SUMMARY     0
`define GIB_BIT_LOAD_FAIL   0
`define GIB_BIT_CRC_ERR     1
`define GIB_BIT_LOAD_DONE   0
`define GIB_RST_BYTE        8'h00
`endif

// >>> design/gib_sticky_bit.v
// one sticky alarm bit with write-one-to-clear and its enable
`timescale 1ns/1ns
module gib_sticky_bit
(
  // clock and reset
  input  wire clk_sys,
  input  wire nrst,
  // alarm event, synchronous to clk_sys
  input  wire alarm,
  // clear and enable write strobes
  input  wire clr,
  input  wire en_wr,
  input  wire en_val,
  // state
  output reg  sticky,
  output reg  enable,
  output wire active
);

  always @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      sticky <= 1'b0;
      enable <= 1'b0;
    end
    else
    begin
      // set wins over a clear in the same cycle
      if (alarm)
        sticky <= 1'b1;
      else if (clr)
        sticky <= 1'b0;
      if (en_wr)
        enable <= en_val;
    end
  end

  assign active = sticky & enable;

endmodule

// >>> design/gib_global_status.v
// global interrupt summary and configuration boot status block
// Summary of operation
// - With no enabled alarm status bit set the summary reads 0 and the interrupt pin is released.
// - With any enabled alarm status bit set the summary reads 1 and the pin is driven low; the summary is read-only.
// - A checksum mismatch on the configuration load sets a read-only flag that only reset clears.
// - A failed configuration read sets a read-only flag that writes cannot clear, only reset.
// - Completion of the configuration read sets a read-only done flag held until reset.
// - Each alarm sets its sticky status bit, which holds until the host writes 1 to it.
// - A status bit reaches the summary and pin only when its enable is 1, enables reset to 0.
`timescale 1ns/1ns
`include "gib_defs.vh"
module gib_global_status
#(
  parameter NUM_REF = `GIB_NUM_REF
)
(
  // clock and reset
  input  wire                   clk_sys,
  input  wire                   nrst,
  // register port from the serial control port
  input  wire [`GIB_ADDR_W-1:0] reg_addr,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  input  wire [`GIB_DATA_W-1:0] reg_wdata,
  output reg  [`GIB_DATA_W-1:0] reg_rdata,
  // alarm events, one-cycle or level
  input  wire                   lock_loss_evt,
  input  wire                   holdover_evt,
  input  wire [NUM_REF-1:0]     signal_loss_evt,
  // boot loader results, pulses
  input  wire                   boot_done_evt,
  input  wire                   boot_fail_evt,
  input  wire                   boot_crc_evt,
  // interrupt pin, active low open drain
  output wire                   irq_line_low,
  output wire                   irq_line_low_oe,
  // flags
  output wire                   irq_summary,
  output reg                    config_load_done,
  output reg                    config_load_failed,
  output reg                    eeprom_crc_mismatch
);

  // ************************************************************
  // alarm bit map: index 0..NUM_REF-1 los, then hold, then lol
  // ************************************************************
  localparam NBIT = NUM_REF + 2;

  wire            wr_stat = reg_wr & (reg_addr == `GIB_ADDR_INT_STAT);
  wire            wr_en   = reg_wr & (reg_addr == `GIB_ADDR_INT_EN);
  wire [NBIT-1:0] alarm;
  wire [NBIT-1:0] sticky;
  wire [NBIT-1:0] enable;
  wire [NBIT-1:0] active;
  wire [7:0]      stat_byte;
  wire [7:0]      en_byte;

  assign alarm = {lock_loss_evt, holdover_evt, signal_loss_evt};

  genvar i;
  generate
    for (i = 0; i < NBIT; i = i + 1)
    begin : g_alarm
      localparam POS = (i == NBIT - 1) ? `GIB_BIT_LOL :
                       (i == NBIT - 2) ? `GIB_BIT_HOLD : i;
      gib_sticky_bit u_bit
      (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .alarm   (alarm[i]),
        .clr     (wr_stat & reg_wdata[POS]),
        .en_wr   (wr_en),
        .en_val  (reg_wdata[POS]),
        .sticky  (sticky[i]),
        .enable  (enable[i]),
        .active  (active[i])
      );
      assign stat_byte[POS] = sticky[i];
      assign en_byte[POS]   = enable[i];
    end
  endgenerate

  // unused byte positions read as zero
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_fill
      if (!(i < NUM_REF || i == `GIB_BIT_HOLD || i == `GIB_BIT_LOL))
      begin : g_zero
        assign stat_byte[i] = 1'b0;
        assign en_byte[i]   = 1'b0;
      end
    end
  endgenerate

  // ************************************************************
  // summary and interrupt pin
  // ************************************************************
  assign irq_summary     = |active;
  assign irq_line_low    = 1'b0;
  assign irq_line_low_oe = irq_summary;

  // ************************************************************
  // boot status flags, only reset clears them
  // ************************************************************
  reg next_load_done;
  reg next_load_failed;
  reg next_crc_mismatch;

  // the loader pulses only set these; no register write reaches them
  always @*
  begin
    next_load_done    = config_load_done;
    next_load_failed  = config_load_failed;
    next_crc_mismatch = eeprom_crc_mismatch;
    if (boot_done_evt)
      next_load_done = 1'b1;
    if (boot_fail_evt)
      next_load_failed = 1'b1;
    if (boot_crc_evt)
      next_crc_mismatch = 1'b1;
  end

  always @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      config_load_done    <= 1'b0;
      config_load_failed  <= 1'b0;
      eeprom_crc_mismatch <= 1'b0;
    end
    else
    begin
      config_load_done    <= next_load_done;
      config_load_failed  <= next_load_failed;
      eeprom_crc_mismatch <= next_crc_mismatch;
    end
  end

  // ************************************************************
  // read address decode
  // ************************************************************
  wire rd_stat;
  wire rd_en;
  wire rd_sum;
  wire rd_err;
  wire rd_done;
  wire rd_other;

  assign rd_stat  = reg_rd & (reg_addr == `GIB_ADDR_INT_STAT);
  assign rd_en    = reg_rd & (reg_addr == `GIB_ADDR_INT_EN);
  assign rd_sum   = reg_rd & (reg_addr == `GIB_ADDR_SUMMARY);
  assign rd_err   = reg_rd & (reg_addr == `GIB_ADDR_BOOT_ERR);
  assign rd_done  = reg_rd & (reg_addr == `GIB_ADDR_BOOT_DONE);
  // reserved and unmapped bytes
  assign rd_other = reg_rd & ~(rd_stat | rd_en | rd_sum | rd_err | rd_done);

  // ************************************************************
  // read byte images, reserved bits read zero
  // ************************************************************
  wire [7:0] sum_byte;
  wire [7:0] err_byte;
  wire [7:0] done_byte;

  assign sum_byte  = {7'h00, irq_summary};
  assign err_byte  = {6'h00, eeprom_crc_mismatch, config_load_failed};
  assign done_byte = {7'h00, config_load_done};

  // ************************************************************
  // read data register, holds until the next read
  // ************************************************************
  reg [7:0] next_rdata;

  always @*
  begin
    next_rdata = reg_rdata;
    if (rd_stat)
      next_rdata = stat_byte;
    else if (rd_en)
      next_rdata = en_byte;
    else if (rd_sum)
      next_rdata = sum_byte;
    else if (rd_err)
      next_rdata = err_byte;
    else if (rd_done)
      next_rdata = done_byte;
    else if (rd_other)
      next_rdata = `GIB_RST_BYTE;
  end

  always @(posedge clk_sys)
  begin
    if (!nrst)
      reg_rdata <= `GIB_RST_BYTE;
    else
      reg_rdata <= next_rdata;
  end

endmodule

// >>> dv/gib_boot_model.sv
// boot loader result model driving the configuration load pulses
`timescale 1ns/1ns
module gib_boot_model
(
  input  wire       clk_sys,
  input  wire       go,
  input  wire [1:0] kind,
  output reg        boot_done_evt, boot_fail_evt, boot_crc_evt
);
  // a failed or corrupt load still ends its read cycle
  initial {boot_done_evt, boot_fail_evt, boot_crc_evt} = 3'b000;
  always @(posedge clk_sys)
    {boot_done_evt, boot_fail_evt, boot_crc_evt} <= {go, go & kind[0], go & kind[1]};
endmodule

// >>> dv/gib_global_status_sva.sv
// port assertions for the global status block
`timescale 1ns/1ns
module gib_global_status_sva
(
  input wire        clk_sys, nrst, reg_wr, reg_rd, lock_loss_evt,
  input wire        boot_done_evt, boot_fail_evt, boot_crc_evt,
  input wire [15:0] reg_addr,
  input wire [7:0]  reg_wdata, reg_rdata,
  input wire        irq_line_low, irq_line_low_oe, irq_summary,
  input wire        config_load_done, config_load_failed, eeprom_crc_mismatch
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_sum_rd; reg_rd && reg_addr == 16'h020d; endsequence
  sequence s_stat_rd; reg_rd && !reg_wr && reg_addr == 16'h0200; endsequence
  sequence s_en_off; reg_wr && reg_addr == 16'h0208 && reg_wdata == 8'h00;
  endsequence
  property p_rel; !irq_summary |-> !irq_line_low_oe; endproperty
  property p_drv; irq_summary |-> irq_line_low_oe && !irq_line_low; endproperty
  property p_crc;
    eeprom_crc_mismatch == $past(eeprom_crc_mismatch | boot_crc_evt);
  endproperty
  property p_fail;
    config_load_failed == $past(config_load_failed | boot_fail_evt);
  endproperty
  property p_done;
    config_load_done == $past(config_load_done | boot_done_evt);
  endproperty
  property p_lol; lock_loss_evt ##1 s_stat_rd |=> reg_rdata[6]; endproperty
  property p_en; s_en_off |=> !irq_summary; endproperty
  property p_sum; s_sum_rd |=> reg_rdata == {7'h00, $past(irq_summary)};
  endproperty
  a_rel: assert property (p_rel) else $error("pin held, summary 0");
  a_drv: assert property (p_drv) else $error("pin free, summary 1");
  a_crc: assert property (p_crc) else $error("crc flag wrong");
  a_fail: assert property (p_fail) else $error("fail flag wrong");
  a_done: assert property (p_done) else $error("done flag wrong");
  a_lol: assert property (p_lol) else $error("lock loss not held");
  a_en: assert property (p_en) else $error("masked bit seen");
  a_sum: assert property (p_sum) else $error("summary read wrong");
endmodule
bind gib_global_status gib_global_status_sva u_sva (.*);

// >>> dv/gib_global_status_bench.sv
// self-checking bench for the global status block
`timescale 1ns/1ns
module gib_global_status_bench;
  reg        clk_sys = 0, nrst = 0, reg_wr = 0, reg_rd = 0, go = 0;
  reg        lock_loss_evt = 0, holdover_evt = 0;
  reg  [1:0] signal_loss_evt = 0, kind = 0;
  reg [15:0] reg_addr = 0;
  reg  [7:0] reg_wdata = 0;
  wire [7:0] reg_rdata;
  wire       boot_done_evt, boot_fail_evt, boot_crc_evt, irq_line_low;
  wire       irq_line_low_oe, irq_summary, config_load_done;
  wire       config_load_failed, eeprom_crc_mismatch;
  integer    error_cnt = 0, tests_run = 0;
  always #5 clk_sys = ~clk_sys;
  gib_boot_model u_boot (.*);
  gib_global_status uut (.*);
  task chk(input string n, input [7:0] s, input [7:0] e);
  begin
    tests_run = tests_run + 1;
    if (s !== e)
    begin
      error_cnt = error_cnt + 1;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  end
  endtask
  task wr(input [15:0] a, input [7:0] d);
  begin
    @(negedge clk_sys) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clk_sys) reg_wr = 0;
  end
  endtask
  task rd(input [15:0] a, input [7:0] e);
  begin
    @(negedge clk_sys) {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clk_sys) reg_rd = 0;
    chk("rdata", reg_rdata, e);
  end
  endtask
  task t_alarm;
  begin
    rd(16'h0208, 8'h00);
    @(negedge clk_sys) {lock_loss_evt, holdover_evt, signal_loss_evt} = 4'he;
    rd(16'h0200, 8'h52);
    {lock_loss_evt, holdover_evt, signal_loss_evt} = 4'h0;
    chk("oe", irq_line_low_oe, 0);
    wr(16'h0208, 8'h40);
    rd(16'h020d, 8'h01);
    chk("pin", {irq_line_low_oe, irq_line_low}, 2'b10);
    chk("sum", irq_summary, 1);
    wr(16'h020d, 8'h00);
    wr(16'h0200, 8'h10);
    rd(16'h0200, 8'h42);
    wr(16'h0200, 8'h40);
    chk("oe", irq_line_low_oe, 0);
    rd(16'h020d, 8'h00);
    wr(16'h020e, 8'h00);
    wr(16'h0208, 8'h02);
    chk("oe", irq_line_low_oe, 1);
    wr(16'h0208, 8'h00);
    chk("oe", irq_line_low_oe, 0);
  end
  endtask
  task t_boot;
  begin
    rd(16'h0211, 8'h00);
    @(negedge clk_sys) {go, kind} = 3'b110;
    @(negedge clk_sys) {go, kind} = 3'b101;
    @(negedge clk_sys) go = 0;
    wr(16'h0210, 8'h03);
    wr(16'h0211, 8'h01);
    rd(16'h0210, 8'h03);
    rd(16'h0211, 8'h01);
    @(negedge clk_sys) nrst = 0;
    repeat (2) @(negedge clk_sys);
    nrst = 1;
    chk("flags", {config_load_done, config_load_failed, eeprom_crc_mismatch}, 0);
    chk("oe", irq_line_low_oe, 0);
  end
  endtask
  task wrap_up;
  begin
    $display("error_cnt %0d tests_run %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  initial
  begin
    repeat (20) @(negedge clk_sys);
    nrst = 1;
    t_alarm;
    t_boot;
    wrap_up;
  end
  // all scenarios finish in well under a thousand cycles
  initial
  begin
    #20000;
    error_cnt = error_cnt + 1;
    wrap_up;
  end
endmodule
